// file: shared/fidoc_map.svh
`ifndef FIDOC_MAP_SVH
`define FIDOC_MAP_SVH

// APB register byte offsets.
`define FIDOC_OFF_CTRL 12'h000
`define FIDOC_OFF_FLAGS 12'h004
`define FIDOC_OFF_OPCODE 12'h008
`define FIDOC_OFF_STATUS 12'h00C
`define FIDOC_OFF_RES_A 12'h010
`define FIDOC_OFF_RES_D 12'h014
`define FIDOC_OFF_VCS 12'h018
`define FIDOC_OFF_VSEL 12'h01C
`define FIDOC_OFF_VDATA 12'h020
`define FIDOC_OFF_SSE3CNT 12'h024

// Flags register bit positions.
`define FIDOC_BIT_ALIGN 18
`define FIDOC_BIT_VIRQ 19
`define FIDOC_BIT_VIRQ_PEND 20
`define FIDOC_BIT_IDENT 21

// Feature result bit positions.
`define FIDOC_D_FPU 0
`define FIDOC_D_TSC 4
`define FIDOC_D_MSR 5
`define FIDOC_D_CX8 8
`define FIDOC_D_CMOV 15
`define FIDOC_A_FAM_LO 8
`define FIDOC_A_FAM_HI 11
`define FIDOC_FAMILY 4'h6

// Control register field positions.
`define FIDOC_CTRL_HAS_ALIGN 0
`define FIDOC_CTRL_HAS_VME 1
`define FIDOC_CTRL_HAS_IDENT 2

// Reset values.
`define FIDOC_CTRL_RST 32'h0000_0007
`define FIDOC_VCS_RST 32'h0000_1F80
`define FIDOC_FLAGS_RST 32'h0000_0002

// Opcode classes presented in the opcode register low byte.
`define FIDOC_OP_NOP 8'h00
`define FIDOC_OP_MOV_TR_TO 8'h01
`define FIDOC_OP_MOV_TR_FROM 8'h02
`define FIDOC_OP_IDENT 8'h03
`define FIDOC_OP_TSC 8'h04
`define FIDOC_OP_MSR_RD 8'h05
`define FIDOC_OP_MSR_WR 8'h06
`define FIDOC_OP_CX8 8'h07
`define FIDOC_OP_PMC 8'h08
`define FIDOC_OP_UNDEF_TRAP 8'h09
`define FIDOC_OP_FCMOV 8'h0A
`define FIDOC_OP_FP_CMP 8'h0B
`define FIDOC_OP_SSE3_FIRST 8'h10
`define FIDOC_OP_SIMD_LAST 8'h19
`define FIDOC_OP_CVT 8'h1A
`define FIDOC_OP_SSE3_LAST 8'h1C
`define FIDOC_SSE3_COUNT 13
`define FIDOC_VREG_NUM 8
`define FIDOC_VREG_WIDTH 128

`endif

// file: shared/fidoc_pkg.sv
package fidoc_pkg;

  typedef enum logic [1:0] {
    FIDOC_CLS_LEGAL,
    FIDOC_CLS_RETIRED,
    FIDOC_CLS_RESERVED
  } fidoc_cls_t;

  typedef enum logic [2:0] {
    FIDOC_SSE3_SIMD,
    FIDOC_SSE3_FISTTP,
    FIDOC_SSE3_SYNC,
    FIDOC_SSE3_NONE
  } fidoc_sse3_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic valid;
  } fidoc_op_t;

  typedef struct packed {
    fidoc_cls_t cls;
    fidoc_sse3_t sse3;
    logic ident;
  } fidoc_dec_t;

  typedef struct packed {
    logic [31:0] res_a;
    logic [31:0] res_d;
  } fidoc_ident_t;

endpackage

// file: verilog/fidoc_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "fidoc_map.svh"

module fidoc_decode
  import fidoc_pkg::*;
(
  // Opcode in.
  input wire fidoc_op_t op,
  // Decode out.
  output fidoc_dec_t dec
);

  always_comb begin
    dec.cls = FIDOC_CLS_LEGAL;
    dec.sse3 = FIDOC_SSE3_NONE;
    dec.ident = 1'b0;
    if (op.opcode == `FIDOC_OP_MOV_TR_TO || op.opcode == `FIDOC_OP_MOV_TR_FROM) begin
      dec.cls = FIDOC_CLS_RETIRED;
    end else if (op.opcode >= `FIDOC_OP_SSE3_FIRST && op.opcode <= `FIDOC_OP_SSE3_LAST) begin
      if (op.opcode <= `FIDOC_OP_SIMD_LAST) begin
        dec.sse3 = FIDOC_SSE3_SIMD;
      end else if (op.opcode == `FIDOC_OP_CVT) begin
        dec.sse3 = FIDOC_SSE3_FISTTP;
      end else begin
        dec.sse3 = FIDOC_SSE3_SYNC;
      end
    end else if (op.opcode > `FIDOC_OP_FP_CMP) begin
      dec.cls = FIDOC_CLS_RESERVED;
    end
    if (op.valid && op.opcode == `FIDOC_OP_IDENT) begin
      dec.ident = 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: verilog/fidoc_vregs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fidoc_map.svh"

module fidoc_vregs
  import fidoc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Word access.
  input wire logic [4:0] sel,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data
);

  // Eight 128-bit vector registers, reached one 32-bit word at a time.
  logic [`FIDOC_VREG_WIDTH-1:0] vector_reg [`FIDOC_VREG_NUM];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `FIDOC_VREG_NUM; i++) begin
        vector_reg[i] <= '0;
      end
    end else if (wr_en) begin
      vector_reg[sel[4:2]][sel[1:0]*32 +: 32] <= wr_data;
    end
  end

  assign rd_data = vector_reg[sel[4:2]][sel[1:0]*32 +: 32];

endmodule

`default_nettype wire

// file: verilog/fidoc_top.sv
// Overview of operation
// - Moves to or from the retired test registers raise the invalid-opcode exception and transfer nothing.
// - Every reserved opcode raises the invalid-opcode exception and has no other effect.
// - The flags register holds the virtual interrupt flag at 19, its pending flag at 20, the ident flag at 21.
// - The alignment-check flag sits at bit 18 and reads clear when not implemented.
// - With the ident instruction present, software can set and clear the ident flag.
// - Without virtual-mode extensions bits 19 and 20 always read zero.
// - Result-d bits 0 and 15 are both set to report fp conditional move and fp compare-set-flags.
// - Result-d bit 8 reports the eight-byte compare-and-exchange.
// - Result-d bit 4 reports the time-stamp read.
// - Result-d bit 5 reports both model register read and write.
// - Result-a bits 8 to 11 hold family 6 to report performance read and the trap instruction.
// - The vector unit has eight 128-bit registers and one 32-bit control and status register.
// - The third vector extension adds 13 instructions: ten SIMD, one conversion, two synchronization.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fidoc_map.svh"

module fidoc_top
  import fidoc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Exception event.
  output logic invalid_opcode_exc
);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------

  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] next_prdata;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_opcode;
  logic wr_status;
  logic wr_vcs;
  logic wr_vsel;
  logic wr_vdata;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `FIDOC_OFF_CTRL) || (a == `FIDOC_OFF_FLAGS) ||
                (a == `FIDOC_OFF_OPCODE) || (a == `FIDOC_OFF_STATUS) ||
                (a == `FIDOC_OFF_RES_A) || (a == `FIDOC_OFF_RES_D) ||
                (a == `FIDOC_OFF_VCS) || (a == `FIDOC_OFF_VSEL) ||
                (a == `FIDOC_OFF_VDATA) || (a == `FIDOC_OFF_SSE3CNT);
  endfunction

  // The slave answers one cycle after setup; writes land on that access edge.
  assign setup = psel && !penable;
  assign mapped = is_mapped(paddr);
  assign wr = psel && penable && pready && pwrite && mapped;
  assign rd = psel && penable && pready && !pwrite;

  // One strobe per writable register keeps the address compares out of the state logic below.
  assign wr_ctrl = wr && paddr == `FIDOC_OFF_CTRL;
  assign wr_flags = wr && paddr == `FIDOC_OFF_FLAGS;
  assign wr_opcode = wr && paddr == `FIDOC_OFF_OPCODE;
  assign wr_status = wr && paddr == `FIDOC_OFF_STATUS;
  assign wr_vcs = wr && paddr == `FIDOC_OFF_VCS;
  assign wr_vsel = wr && paddr == `FIDOC_OFF_VSEL;
  assign wr_vdata = wr && paddr == `FIDOC_OFF_VDATA;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------

  logic [31:0] ctrl;
  logic [31:0] flags;
  logic [7:0] last_opcode;
  logic ud_sticky;
  logic retired_sticky;
  logic [31:0] vector_ctrl_status;
  logic [4:0] vsel;
  logic [3:0] sse3_simd_cnt;
  logic [3:0] sse3_other_cnt;
  logic [31:0] vrd;
  logic op_fire;
  fidoc_op_t op;
  fidoc_dec_t dec;
  fidoc_ident_t ident_out;
  logic has_align;
  logic has_vme;
  logic has_ident;
  logic exc_now;

  // Clearing a switch models an older core generation without that feature.
  assign has_align = ctrl[`FIDOC_CTRL_HAS_ALIGN];
  assign has_vme = ctrl[`FIDOC_CTRL_HAS_VME];
  assign has_ident = ctrl[`FIDOC_CTRL_HAS_IDENT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `FIDOC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {29'h0000_0000, pwdata[2:0]};
    end
  end

  // --------------------------------------------------------------------
  // Processor flags
  // --------------------------------------------------------------------

  // Absent bits are forced clear on every write and on a feature drop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= `FIDOC_FLAGS_RST;
    end else begin
      if (wr_flags) begin
        flags <= pwdata;
      end
      if (!has_align) begin
        flags[`FIDOC_BIT_ALIGN] <= 1'b0;
      end
      if (!has_vme) begin
        flags[`FIDOC_BIT_VIRQ] <= 1'b0;
        flags[`FIDOC_BIT_VIRQ_PEND] <= 1'b0;
      end
      if (!has_ident) begin
        flags[`FIDOC_BIT_IDENT] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Opcode check
  // --------------------------------------------------------------------

  assign op_fire = wr_opcode;
  assign op.opcode = pwdata[7:0];
  assign op.valid = op_fire;

  fidoc_decode u_decode (
    .op(op),
    .dec(dec)
  );

  // A feature-probe opcode on a core without the ident flag is reserved too.
  // The pulse and the sticky status share one test, so they can never disagree.
  function automatic logic traps(input fidoc_dec_t d, input logic ident_ok);
    traps = (d.cls != FIDOC_CLS_LEGAL) || (d.ident && !ident_ok);
  endfunction

  assign exc_now = op_fire && traps(dec, has_ident);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      invalid_opcode_exc <= 1'b0;
    end else begin
      invalid_opcode_exc <= exc_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_opcode <= 8'h00;
    end else if (op_fire) begin
      last_opcode <= op.opcode;
    end
  end

  // --------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------

  // Sticky status: a new event wins over a clear written the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ud_sticky <= 1'b0;
      retired_sticky <= 1'b0;
    end else begin
      if (wr_status) begin
        if (pwdata[0]) begin
          ud_sticky <= 1'b0;
        end
        if (pwdata[1]) begin
          retired_sticky <= 1'b0;
        end
      end
      if (exc_now) begin
        ud_sticky <= 1'b1;
      end
      if (op_fire && dec.cls == FIDOC_CLS_RETIRED) begin
        retired_sticky <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Extension counters
  // --------------------------------------------------------------------

  // The counters wrap at sixteen; they only make the split of the third extension visible.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sse3_simd_cnt <= 4'h0;
      sse3_other_cnt <= 4'h0;
    end else if (op_fire && dec.sse3 == FIDOC_SSE3_SIMD) begin
      sse3_simd_cnt <= sse3_simd_cnt + 4'h1;
    end else if (op_fire && dec.sse3 != FIDOC_SSE3_NONE) begin
      sse3_other_cnt <= sse3_other_cnt + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // Identification result
  // --------------------------------------------------------------------

  always_comb begin
    ident_out.res_a = 32'h0000_0000;
    ident_out.res_d = 32'h0000_0000;
    ident_out.res_a[`FIDOC_A_FAM_HI:`FIDOC_A_FAM_LO] = `FIDOC_FAMILY;
    ident_out.res_d[`FIDOC_D_FPU] = 1'b1;
    ident_out.res_d[`FIDOC_D_CMOV] = 1'b1;
    ident_out.res_d[`FIDOC_D_CX8] = 1'b1;
    ident_out.res_d[`FIDOC_D_TSC] = 1'b1;
    ident_out.res_d[`FIDOC_D_MSR] = 1'b1;
  end

  // --------------------------------------------------------------------
  // Vector state
  // --------------------------------------------------------------------

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_ctrl_status <= `FIDOC_VCS_RST;
    end else if (wr_vcs) begin
      vector_ctrl_status <= pwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vsel <= 5'h00;
    end else if (wr_vsel) begin
      vsel <= pwdata[4:0];
    end
  end

  // The selector does not advance on a data access, so software rewrites it before each word of a register.
  fidoc_vregs u_vregs (
    .clk(clk),
    .rst_n(rst_n),
    .sel(vsel),
    .wr_en(wr_vdata),
    .wr_data(pwdata),
    .rd_data(vrd)
  );

  // --------------------------------------------------------------------
  // Read mux and answer
  // --------------------------------------------------------------------

  // Unmapped offsets read as zero, so a probe of a missing register sees nothing stale.
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `FIDOC_OFF_CTRL: next_prdata = ctrl;
      `FIDOC_OFF_FLAGS: next_prdata = flags;
      `FIDOC_OFF_OPCODE: next_prdata = {24'h00_0000, last_opcode};
      `FIDOC_OFF_STATUS: next_prdata = {30'h0000_0000, retired_sticky, ud_sticky};
      `FIDOC_OFF_RES_A: next_prdata = has_ident ? ident_out.res_a : 32'h0000_0000;
      `FIDOC_OFF_RES_D: next_prdata = has_ident ? ident_out.res_d : 32'h0000_0000;
      `FIDOC_OFF_VCS: next_prdata = vector_ctrl_status;
      `FIDOC_OFF_VSEL: next_prdata = {27'h000_0000, vsel};
      `FIDOC_OFF_VDATA: next_prdata = vrd;
      `FIDOC_OFF_SSE3CNT: next_prdata = {24'h00_0000, sse3_other_cnt, sse3_simd_cnt};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Ready rises in the access cycle, so every transfer takes exactly two cycles.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end else if (rd) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// file: dv/fidoc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fidoc_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus and event.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic invalid_opcode_exc
);
  // --------------------------------
  // Bus and opcode properties
  // --------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] op;
  assign op = pwdata[7:0];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_op_wr;
    pready && pwrite && paddr == 12'h008;
  endsequence
  answer_after_setup_a: assert property (s_setup |=> pready) else $error("no answer after setup");
  ready_only_access_a: assert property (!(psel && !penable) |=> !pready) else $error("answer without setup");
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("answer held too long");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("error outside access");
  exc_needs_opcode_a: assert property (!(pready && pwrite && paddr == 12'h008) |=> !invalid_opcode_exc)
    else $error("exception without opcode");
  retired_exc_a: assert property (s_op_wr ##0 (op == 8'h01 || op == 8'h02) |=> invalid_opcode_exc)
    else $error("retired move not trapped");
  reserved_exc_a: assert property (s_op_wr ##0 (op inside {[8'h0C:8'h0F], [8'h1D:8'hFF]}) |=> invalid_opcode_exc)
    else $error("reserved opcode not trapped");
  legal_quiet_a: assert property (s_op_wr ##0 (op inside {8'h00, [8'h04:8'h0B], [8'h10:8'h1C]}) |=> !invalid_opcode_exc)
    else $error("legal opcode trapped");
  read_data_drop_a: assert property (pready && !pwrite |=> prdata == 32'h0) else $error("read data held");
  unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped data");
endmodule
bind fidoc_top fidoc_checker i_fidoc_checker (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .invalid_opcode_exc(invalid_opcode_exc));
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fidoc_map.svh"
module testbench;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, invalid_opcode_exc, last_err;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 9263;
  logic [31:0] vmem [32];
  fidoc_top i_fidoc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .invalid_opcode_exc(invalid_opcode_exc));
  // --------------------------------
  // Clock, timeout and helpers
  // --------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  // The full run needs under two thousand cycles, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task test_done;
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // The upper bytes are random so that only the low byte may pick the opcode.
  task exec(input logic [7:0] op, input logic want);
    logic [31:0] d;
    d = $random(seed);
    d[7:0] = op;
    apb(1, `FIDOC_OFF_OPCODE, d);
    @(posedge clk);
    chk("exc", want, invalid_opcode_exc);
  endtask
  function automatic logic exp_exc(input int op, input logic has_ident);
    return !(op == 0 || (op >= 4 && op <= 11) || (op >= 16 && op <= 28) || (op == 3 && has_ident));
  endfunction
  task rst_chk;
    apb(0, `FIDOC_OFF_CTRL, 0);
    chk("ctrl", 32'h0000_0007, rd);
    apb(0, `FIDOC_OFF_FLAGS, 0);
    chk("flags", 32'h0000_0002, rd);
    apb(0, `FIDOC_OFF_VCS, 0);
    chk("vcs", 32'h0000_1F80, rd);
    apb(0, `FIDOC_OFF_STATUS, 0);
    chk("status", 32'h0, rd);
    apb(0, `FIDOC_OFF_SSE3CNT, 0);
    chk("sse3 reset", 32'h0, rd);
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rst_chk();
    apb(0, 12'h040, 32'h0);
    chk("unmapped err", 1, last_err);
    chk("unmapped data", 0, rd);
    apb(1, 12'h044, 32'hFFFF_FFFF);
    chk("unmapped wr err", 1, last_err);
    for (int c = 0; c < 8; c++) begin
      apb(1, `FIDOC_OFF_CTRL, c);
      apb(1, `FIDOC_OFF_FLAGS, 32'h003C_0000);
      apb(0, `FIDOC_OFF_FLAGS, 0);
      chk("flags set", {c[2], c[1], c[1], c[0]} << 18, rd & 32'h003C_0000);
      apb(1, `FIDOC_OFF_FLAGS, 32'h0);
      apb(0, `FIDOC_OFF_FLAGS, 0);
      chk("flags clear", 0, rd & 32'h003C_0000);
      exec(8'h03, !c[2]);
      apb(0, `FIDOC_OFF_RES_D, 0);
      chk("res_d", c[2] ? 32'h8131 : 32'h0, c[2] ? rd & 32'h8131 : rd);
      apb(0, `FIDOC_OFF_RES_A, 0);
      if (c[2]) chk("family", 4'h6, rd[11:8]);
      else chk("res_a absent", 0, rd);
    end
    for (int op = 0; op < 256; op++) exec(op, exp_exc(op, 1));
    apb(0, `FIDOC_OFF_SSE3CNT, 0);
    chk("sse3 counts", 32'h3A, rd[7:0]);
    apb(0, `FIDOC_OFF_OPCODE, 0);
    chk("last opcode", 32'hFF, rd);
    apb(1, `FIDOC_OFF_STATUS, 32'h3);
    apb(0, `FIDOC_OFF_STATUS, 0);
    chk("status clr", 0, rd & 32'h3);
    exec(8'h02, 1);
    apb(0, `FIDOC_OFF_STATUS, 0);
    chk("status retired", 32'h3, rd & 32'h3);
    apb(1, `FIDOC_OFF_STATUS, 32'h3);
    exec(8'hC0, 1);
    apb(0, `FIDOC_OFF_STATUS, 0);
    chk("status reserved", 32'h1, rd & 32'h3);
    for (int i = 0; i < 32; i++) begin
      vmem[i] = $random(seed);
      apb(1, `FIDOC_OFF_VSEL, i);
      apb(1, `FIDOC_OFF_VDATA, vmem[i]);
    end
    for (int i = 0; i < 32; i++) begin
      apb(1, `FIDOC_OFF_VSEL, i);
      apb(0, `FIDOC_OFF_VDATA, 0);
      chk("vreg word", vmem[i], rd);
    end
    apb(1, `FIDOC_OFF_VCS, vmem[0]);
    apb(0, `FIDOC_OFF_VCS, 0);
    chk("vcs rw", vmem[0], rd);
    apb(1, `FIDOC_OFF_CTRL, 0);
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rst_chk();
    test_done();
  end
endmodule
`default_nettype wire
